// [inc/istc_map.vh]
`ifndef ISTC_MAP_VH
`define ISTC_MAP_VH
// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define ISTC_IDX_FREQ 8'h11
`define ISTC_IDX_PHASE 8'h12
`define ISTC_IDX_H_START 8'h13
`define ISTC_IDX_V_START 8'h14
`define ISTC_IDX_BLACK 8'h15
`define ISTC_IDX_STATUS 8'h20
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ISTC_RST_FREQ 8'h0c
`define ISTC_RST_PHASE 8'h00
`define ISTC_RST_H_START 8'hd8
`define ISTC_RST_V_START 8'h1b
`define ISTC_RST_BLACK 8'hd8
// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define ISTC_FREQ_MSB 3
`define ISTC_FINE_MSB 4
`define ISTC_COARSE_LSB 5
`define ISTC_COARSE_MSB 6
`define ISTC_BYPASS_BIT 7
`define ISTC_V_ACTIVE_START_MSB 5
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define ISTC_H_EXTRA 11'h005
`define ISTC_V_EXTRA 8'h03
`define ISTC_FREQ_RESERVED 4'h0
// ----------------------------------------
// Bus responses
// ----------------------------------------
`define ISTC_RESP_OKAY 2'b00
`define ISTC_RESP_SLVERR 2'b10
`endif

// [rtl/istc_timing.v]
`timescale 1ns/1ps
// Operation
// R1 - Four-bit frequency select in bits 0-3 picks interpolator reference; default 40 MHz.
// R2 - Decode select per mode table; code zero reserved, code 1100 is 40 MHz.
// R3 - Software loads the select matching its loaded feedback and post-scaler dividers.
// R4 - Bits 4-7 of the frequency select register are reserved, no effect.
// R5 - With bypass low, five-bit fine phase gives 32 steps across one period.
// R6 - With bypass high, coarse field bits 5-6 gives 0, 90, 180, 270 degrees.
// R7 - Bit 7 bypasses interpolator, leaving coarse shifts; interpolator may power down.
// R8 - Sampling starts horizontal start plus 5 cycles after Hsync leading edge.
// R9 - First active line is vertical start plus 3 Hsyncs after Vsync edge.
// R10 - Each row starts with a reset-to-black interval of black width cycles.
// R11 - Horizontal counters restart at Hsync edge, vertical counter at Vsync edge.
`include "istc_map.vh"
module istc_timing (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Video sync pins
  input wire hsync_pin,
  input wire vsync_pin,
  // Sampling clock control
  output reg [3:0] ref_freq_select,
  output reg freq_select_invalid,
  output reg [4:0] fine_phase,
  output reg [1:0] coarse_phase_select,
  output reg interp_bypass,
  output reg interp_power_down,
  // Window timing
  output reg sample_start,
  output reg line_active,
  output reg frame_active,
  output reg black_reset
);

  // ----------------------------------------
  // Register decode helper
  // ----------------------------------------
  function [7:0] istc_index;
    input [7:0] addr;
    begin
      istc_index = {2'b00, addr[7:2]};
    end
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg [7:0] freq_reg;
  reg [7:0] phase_reg;
  reg [7:0] h_active_start;
  reg [7:0] v_active_start;
  reg [7:0] black_width;

  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [7:0] w_data;
  reg w_lane0;
  wire wr_go;
  wire [7:0] wr_idx;
  wire wr_hit;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx = istc_index(aw_addr);
  // Writes to unmapped words are dropped and answered with an error
  assign wr_hit = (wr_idx == `ISTC_IDX_FREQ) | (wr_idx == `ISTC_IDX_PHASE) |
                  (wr_idx == `ISTC_IDX_H_START) | (wr_idx == `ISTC_IDX_V_START) |
                  (wr_idx == `ISTC_IDX_BLACK);

  // Write channel capture, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ISTC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `ISTC_RESP_OKAY : `ISTC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register update on a completed write with lane 0 enabled
  always @(posedge aclk) begin
    if (!aresetn) begin
      freq_reg <= `ISTC_RST_FREQ; // R1
      phase_reg <= `ISTC_RST_PHASE;
      h_active_start <= `ISTC_RST_H_START;
      v_active_start <= `ISTC_RST_V_START;
      black_width <= `ISTC_RST_BLACK;
    end else if (wr_go && w_lane0) begin
      case (wr_idx)
        `ISTC_IDX_FREQ: freq_reg <= w_data;
        `ISTC_IDX_PHASE: phase_reg <= w_data;
        `ISTC_IDX_H_START: h_active_start <= w_data;
        `ISTC_IDX_V_START: v_active_start <= {2'b00, w_data[`ISTC_V_ACTIVE_START_MSB:0]}; // R9
        `ISTC_IDX_BLACK: black_width <= w_data;
        default: freq_reg <= freq_reg;
      endcase
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ISTC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ISTC_RESP_OKAY;
      case (istc_index(s_axi_araddr))
        `ISTC_IDX_FREQ: s_axi_rdata <= {24'h00_0000, freq_reg};
        `ISTC_IDX_PHASE: s_axi_rdata <= {24'h00_0000, phase_reg};
        `ISTC_IDX_H_START: s_axi_rdata <= {24'h00_0000, h_active_start};
        `ISTC_IDX_V_START: s_axi_rdata <= {24'h00_0000, v_active_start};
        `ISTC_IDX_BLACK: s_axi_rdata <= {24'h00_0000, black_width};
        `ISTC_IDX_STATUS: s_axi_rdata <= {27'h000_0000, frame_active, line_active,
                                          black_reset, freq_select_invalid,
                                          interp_power_down};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `ISTC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sampling clock control
  // ----------------------------------------
  // Upper nibble of the select register is stored but never decoded
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_freq_select <= 4'h0;
      freq_select_invalid <= 1'b0;
      fine_phase <= 5'h00;
      coarse_phase_select <= 2'h0;
      interp_bypass <= 1'b0;
      interp_power_down <= 1'b0;
    end else begin
      ref_freq_select <= freq_reg[`ISTC_FREQ_MSB:0]; // R1 R4
      freq_select_invalid <= (freq_reg[`ISTC_FREQ_MSB:0] == `ISTC_FREQ_RESERVED); // R2
      interp_bypass <= phase_reg[`ISTC_BYPASS_BIT]; // R7
      interp_power_down <= phase_reg[`ISTC_BYPASS_BIT]; // R7
      // Only the field of the active path is passed, the other reads zero
      fine_phase <= phase_reg[`ISTC_BYPASS_BIT] ? 5'h00 : phase_reg[`ISTC_FINE_MSB:0]; // R5
      coarse_phase_select <= phase_reg[`ISTC_BYPASS_BIT] ?
                             phase_reg[`ISTC_COARSE_MSB:`ISTC_COARSE_LSB] : 2'h0; // R6
    end
  end

  // ----------------------------------------
  // Sync input synchronisers and edge detect
  // ----------------------------------------
  reg hs_meta;
  reg hs_sync;
  reg hs_last;
  reg vs_meta;
  reg vs_sync;
  reg vs_last;
  wire hs_lead;
  wire vs_lead;

  // Two flops per pin before any logic; the third holds the previous level
  always @(posedge aclk) begin
    if (!aresetn) begin
      hs_meta <= 1'b0;
      hs_sync <= 1'b0;
      hs_last <= 1'b0;
      vs_meta <= 1'b0;
      vs_sync <= 1'b0;
      vs_last <= 1'b0;
    end else begin
      hs_meta <= hsync_pin;
      hs_sync <= hs_meta;
      hs_last <= hs_sync;
      vs_meta <= vsync_pin;
      vs_sync <= vs_meta;
      vs_last <= vs_sync;
    end
  end

  // Last levels reset low like the idle pins, so no false edge after reset
  assign hs_lead = hs_sync & ~hs_last;
  assign vs_lead = vs_sync & ~vs_last;

  // ----------------------------------------
  // Horizontal window and black interval
  // ----------------------------------------
  reg [10:0] h_count;
  reg h_run;
  wire [10:0] h_target;
  wire [10:0] next_h_count;

  assign h_target = {3'b000, h_active_start} + `ISTC_H_EXTRA; // R8
  assign next_h_count = h_count + 11'h001;

  always @(posedge aclk) begin
    if (!aresetn) begin
      h_count <= 11'h000;
      h_run <= 1'b0;
      sample_start <= 1'b0;
      line_active <= 1'b0;
      black_reset <= 1'b0;
    end else if (hs_lead) begin
      h_count <= 11'h001; // R11
      h_run <= 1'b1;
      sample_start <= 1'b0;
      line_active <= 1'b0;
      black_reset <= (black_width != 8'h00); // R10
    end else begin
      sample_start <= 1'b0;
      // Keep counting past the sample point while a long black interval runs
      if (h_run || black_reset) begin
        h_count <= next_h_count;
      end
      if (h_run && (h_count == h_target)) begin
        sample_start <= frame_active & ~vs_lead; // R8
        line_active <= frame_active & ~vs_lead;
        h_run <= 1'b0;
      end
      if (black_reset && (h_count >= {3'b000, black_width})) begin
        black_reset <= 1'b0; // R10
      end
    end
  end

  // ----------------------------------------
  // Vertical window
  // ----------------------------------------
  reg [7:0] v_count;
  reg v_run;
  wire [7:0] v_target;

  assign v_target = v_active_start + `ISTC_V_EXTRA; // R9

  // Count Hsync edges after Vsync; a Vsync edge in the same cycle wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      v_count <= 8'h00;
      v_run <= 1'b0;
      frame_active <= 1'b0;
    end else if (vs_lead) begin
      v_count <= 8'h00; // R11
      v_run <= 1'b1;
      frame_active <= 1'b0;
    end else if (v_run && hs_lead) begin
      v_count <= v_count + 8'h01;
      if ((v_count + 8'h01) == v_target) begin
        frame_active <= 1'b1; // R9
        v_run <= 1'b0;
      end
    end
  end

endmodule

// [testbench/istc_sync_src.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Video source model
// ----------------------------------------
module istc_sync_src #(
  parameter LINE = 120,
  parameter FRAME = 12
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Sync pins
  output reg hsync_pin = 1'b0,
  output reg vsync_pin = 1'b0
);
  integer h = 0;
  integer v = 0;
  // Line and frame counters; vsync starts mid-line, clear of hsync
  always @(posedge aclk) begin
    if (!aresetn) begin
      h <= 0;
      v <= 0;
    end else begin
      h <= (h == LINE - 1) ? 0 : h + 1;
      if (h == LINE - 1) v <= (v == FRAME - 1) ? 0 : v + 1;
    end
    hsync_pin <= aresetn && (h < 8);
    vsync_pin <= aresetn && ((v == 0 && h >= 60) || (v == 1 && h < 60));
  end
endmodule

// [testbench/istc_timing_asserts.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Output checker
// ----------------------------------------
module istc_checker (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Clock control outputs
  input wire [3:0] ref_freq_select,
  input wire freq_select_invalid,
  input wire [4:0] fine_phase,
  input wire [1:0] coarse_phase_select,
  input wire interp_bypass,
  input wire interp_power_down,
  // Window outputs
  input wire sample_start,
  input wire line_active,
  input wire frame_active,
  input wire black_reset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_frq; $rose(aresetn) |-> ##3 ref_freq_select == 4'hc; endproperty
  property p_val; (ref_freq_select != 4'h0) [*2] |-> !freq_select_invalid; endproperty
  property p_fin; !interp_bypass |-> coarse_phase_select == 2'b00; endproperty
  property p_crs; interp_bypass |-> fine_phase == 5'h00; endproperty
  property p_pdn; interp_power_down == interp_bypass; endproperty
  property p_pls; sample_start |=> !sample_start; endproperty
  property p_lin; sample_start |=> line_active; endproperty
  property p_frm; sample_start |-> frame_active; endproperty
  property p_blk; $rose(black_reset) |-> !line_active; endproperty
  a_frq: assert property (p_frq) else $error("select not at default");
  a_val: assert property (p_val) else $error("valid code flagged");
  a_fin: assert property (p_fin) else $error("coarse used unbypassed");
  a_crs: assert property (p_crs) else $error("fine used bypassed");
  a_pdn: assert property (p_pdn) else $error("power down mismatch");
  a_pls: assert property (p_pls) else $error("start not a pulse");
  a_lin: assert property (p_lin) else $error("line not active");
  a_frm: assert property (p_frm) else $error("start outside frame");
  a_blk: assert property (p_blk) else $error("line not restarted");
  c_smp: cover property (sample_start);
  c_byp: cover property (interp_bypass);
  c_blk: cover property ($rose(black_reset));
endmodule
bind istc_timing istc_checker i_istc_checker (.aclk, .aresetn, .ref_freq_select,
  .freq_select_invalid, .fine_phase, .coarse_phase_select, .interp_bypass,
  .interp_power_down, .sample_start, .line_active, .frame_active, .black_reset);

// [testbench/tb.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [7:0] s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, coarse_phase_select;
  wire [31:0] s_axi_rdata;
  wire [3:0] ref_freq_select;
  wire [4:0] fine_phase;
  wire hsync_pin, vsync_pin, freq_select_invalid, interp_bypass, interp_power_down;
  wire sample_start, line_active, frame_active, black_reset;
  integer errors = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer n, w, t, i;
  istc_timing i_istc_timing (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .hsync_pin(hsync_pin), .vsync_pin(vsync_pin),
    .ref_freq_select(ref_freq_select), .freq_select_invalid(freq_select_invalid),
    .fine_phase(fine_phase), .coarse_phase_select(coarse_phase_select),
    .interp_bypass(interp_bypass), .interp_power_down(interp_power_down),
    .sample_start(sample_start), .line_active(line_active), .frame_active(frame_active),
    .black_reset(black_reset)
  );
  istc_sync_src i_istc_sync_src (
    .aclk(aclk), .aresetn(aresetn), .hsync_pin(hsync_pin), .vsync_pin(vsync_pin)
  );
  // Clock
  initial forever #2.5 aclk = ~aclk;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bus write, both channels offered together
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ta, tw, tv;
    reg [1:0] r;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(negedge aclk);
        ta = s_axi_awready;
        tw = s_axi_wready;
        tv = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge aclk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
      end while (!tv);
      s_axi_bready <= 1'b0;
      chk(32'(r), 32'(er));
    end
  endtask
  // Bus read, whole word compared with the expected byte zero-extended
  task rd(input [7:0] a, input [7:0] e, input [1:0] er);
    reg ta, tv;
    reg [31:0] d;
    reg [1:0] r;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(negedge aclk);
        ta = s_axi_arready;
        tv = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        if (ta) s_axi_arvalid <= 1'b0;
      end while (!tv);
      s_axi_rready <= 1'b0;
      chk(d, 32'(e));
      chk(32'(r), 32'(er));
    end
  endtask
  task settle;
    repeat (3) @(negedge aclk);
  endtask
  // Row count, black width and black-to-sample distance up to next sample
  task meas;
    reg p;
    begin
      n = 0;
      w = 0;
      t = 0;
      @(negedge aclk);
      p = black_reset;
      while (!sample_start) begin
        if (black_reset && !p) begin
          n = n + 1;
          w = 0;
          t = 0;
        end
        if (black_reset) w = w + 1;
        t = t + 1;
        p = black_reset;
        @(negedge aclk);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Timeout
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("FAIL %0t timeout", $time);
      errors = errors + 1;
      report_and_stop;
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h44, 8'h0c, 2'b00);
    rd(8'h48, 8'h00, 2'b00);
    rd(8'h4c, 8'hd8, 2'b00);
    rd(8'h50, 8'h1b, 2'b00);
    rd(8'h54, 8'hd8, 2'b00);
    chk(32'(ref_freq_select), 32'(4'hc));
    wr(8'h44, 32'h0000_00f3, 2'b00);
    settle;
    chk(32'(ref_freq_select), 32'(4'h3));
    for (i = 0; i < 16; i = i + 1) begin
      wr(8'h44, 32'(i), 2'b00);
      settle;
      chk(32'(ref_freq_select), 32'(i));
      chk(32'(freq_select_invalid), 32'(i == 0));
    end
    wr(8'h44, 32'h0000_000c, 2'b00);
    wr(8'h50, 32'h0000_00ff, 2'b00);
    rd(8'h50, 8'h3f, 2'b00);
    wr(8'h58, 32'h0000_0011, 2'b10);
    rd(8'h58, 8'h00, 2'b10);
    wr(8'h48, 32'h0000_001f, 2'b00);
    settle;
    chk(32'({interp_bypass, interp_power_down, coarse_phase_select, fine_phase}), 32'h1f);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h48, 32'h95 | (i << 5), 2'b00);
      settle;
      chk(32'({interp_bypass, interp_power_down, coarse_phase_select}), 32'(12 + i));
      chk(32'(fine_phase), 32'h0);
    end
    wr(8'h4c, 32'h0000_0014, 2'b00);
    wr(8'h50, 32'h0000_0002, 2'b00);
    s_axi_wstrb <= 4'h0;
    wr(8'h54, 32'h0000_0077, 2'b00);
    s_axi_wstrb <= 4'hf;
    rd(8'h54, 8'hd8, 2'b00);
    wr(8'h54, 32'h0000_000a, 2'b00);
    @(posedge vsync_pin);
    meas;
    chk(n, 5);
    chk(w, 10);
    chk(t, 25);
    meas;
    chk(n, 1);
    chk(w, 10);
    chk(t, 25);
    rd(8'h80, 8'h19, 2'b00);
    report_and_stop;
  end
endmodule
